// ==== design/mdbs_top.sv ====
// Shared mailbox, doorbell and semaphore block between host bus and local port
`default_nettype none

module mdbs_top
(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [mdbs_pkg::ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output var  logic                          s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output var  logic                          s_axi_wready,
   output var  logic [1:0]                    s_axi_bresp,
   output var  logic                          s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [mdbs_pkg::ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output var  logic                          s_axi_arready,
   output var  logic [31:0]                   s_axi_rdata,
   output var  logic [1:0]                    s_axi_rresp,
   output var  logic                          s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic                          local_chip_select_n,
   input  wire logic                          local_read_strobe_n,
   input  wire logic                          local_write_strobe_n,
   input  wire logic                          local_reg_select_0,
   input  wire logic                          local_reg_select_1,
   input  wire logic [7:0]                    local_data_bus_in,
   output var  logic [7:0]                    local_data_bus_out,
   output var  logic                          local_data_bus_oe_n,
   output var  logic                          local_ready_out,
   output var  logic                          board_irq_out,
   output var  logic                          host_irq_out
);

   // ----------------------------------------------------------------
   // Shared state
   // ----------------------------------------------------------------
   logic [mdbs_pkg::NUM_SEM-1:0]  sem_flag;
   logic [mdbs_pkg::NUM_SEM-1:0]  sem_test_host;
   logic [mdbs_pkg::NUM_SEM-1:0]  sem_test_local;
   logic [7:0]                    mbox [mdbs_pkg::NUM_MBOX];
   logic [7:0]                    local_db;
   logic [7:0]                    local_db_en;
   logic [7:0]                    sys_db;
   logic [7:0]                    sys_db_en;
   logic                          local_int_en;
   logic                          sys_int_en;
   logic                          local_db_active;
   logic                          sys_db_active;
   mdbs_pkg::mdbs_wr_s            host_wr;
   mdbs_pkg::mdbs_wr_s            local_wr;

   assign local_db_active = |(local_db & local_db_en);
   assign sys_db_active   = |(sys_db & sys_db_en);

   // Reads sample whole registers in one clock, so no byte is ever torn
   function automatic logic [7:0] read_shared(input logic [4:0] idx, input logic from_host);
      logic [7:0] v;
      v = 8'h00;
      if (idx >= mdbs_pkg::IDX_MBOX_BASE)
      begin
         v = mbox[idx[3:0]];
      end
      else
      begin
         unique case (idx)
            mdbs_pkg::IDX_SEM0, mdbs_pkg::IDX_SEM1:
            begin
               v[mdbs_pkg::SEM_FLAG_BIT] = sem_flag[idx[0]];
               v[mdbs_pkg::SEM_TEST_BIT] = from_host ? sem_test_host[idx[0]]
                                                     : sem_test_local[idx[0]];
            end
            mdbs_pkg::IDX_LDB:          v = local_db;
            mdbs_pkg::IDX_LDB_EN:       v = local_db_en;
            mdbs_pkg::IDX_SDB:          v = sys_db;
            mdbs_pkg::IDX_SDB_EN:       v = sys_db_en;
            mdbs_pkg::IDX_SYS_INT_CTRL:
            begin
               v[mdbs_pkg::CTRL_EN_BIT]  = sys_int_en;
               v[mdbs_pkg::CTRL_DB_BIT]  = sys_db_active;
               v[mdbs_pkg::CTRL_IRQ_BIT] = host_irq_out;
            end
            default:                    v = 8'h00;
         endcase
      end
      read_shared = v;
   endfunction

   // ----------------------------------------------------------------
   // Host register bus, write path
   // ----------------------------------------------------------------
   logic [mdbs_pkg::ADDR_W-1:0]   aw_addr;
   logic [7:0]                    w_byte;
   logic                          w_lane0;
   logic                          wr_fire;
   logic                          wr_mapped;

   assign wr_fire   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_mapped = (aw_addr[mdbs_pkg::ADDR_W-1:7] == '0) &&
                      (aw_addr[1:0] == 2'h0) &&
                      mdbs_pkg::is_shared({3'h0, aw_addr[6:2]});
   assign host_wr.en   = wr_fire && wr_mapped && w_lane0;
   assign host_wr.idx  = aw_addr[6:2];
   assign host_wr.data = w_byte;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b1;
         aw_addr       <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         s_axi_awready <= 1'b0;
         aw_addr       <= s_axi_awaddr;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_axi_wready <= 1'b1;
         w_byte       <= 8'h00;
         w_lane0      <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         s_axi_wready <= 1'b0;
         w_byte       <= s_axi_wdata[7:0];
         w_lane0      <= s_axi_wstrb[0];
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= mdbs_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? mdbs_pkg::RESP_OKAY : mdbs_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Host register bus, read path
   // ----------------------------------------------------------------
   logic rd_mapped;

   assign rd_mapped = (s_axi_araddr[mdbs_pkg::ADDR_W-1:7] == '0) &&
                      (s_axi_araddr[1:0] == 2'h0) &&
                      mdbs_pkg::is_shared({3'h0, s_axi_araddr[6:2]});

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= mdbs_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mapped ? {24'h0, read_shared(s_axi_araddr[6:2], 1'b1)} : 32'h0;
         s_axi_rresp   <= rd_mapped ? mdbs_pkg::RESP_OKAY : mdbs_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Local port: pin synchroniser and strobe handling
   // ----------------------------------------------------------------
   mdbs_pkg::mdbs_lpin_s   pin_meta;
   mdbs_pkg::mdbs_lpin_s   pin_sync;
   mdbs_pkg::mdbs_lp_e     lp_state;
   logic [7:0]             local_index;
   logic                   lp_rd;
   logic                   lp_wr;
   logic                   idx_shared;
   logic [7:0]             local_status;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pin_meta <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sel: 2'h0, data: 8'h00};
         pin_sync <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sel: 2'h0, data: 8'h00};
      end
      else
      begin
         pin_meta <= '{cs_n: local_chip_select_n, rd_n: local_read_strobe_n,
                       wr_n: local_write_strobe_n,
                       sel: {local_reg_select_1, local_reg_select_0},
                       data: local_data_bus_in};
         pin_sync <= pin_meta;
      end
   end

   assign lp_rd      = !pin_sync.cs_n && !pin_sync.rd_n;
   assign lp_wr      = !pin_sync.cs_n && !pin_sync.wr_n;
   assign idx_shared = mdbs_pkg::is_shared(local_index);

   always_comb
   begin
      local_status = 8'h00;
      local_status[mdbs_pkg::CTRL_EN_BIT]  = local_int_en;
      local_status[mdbs_pkg::CTRL_DB_BIT]  = local_db_active;
      local_status[mdbs_pkg::CTRL_IRQ_BIT] = board_irq_out;
   end

   // One access per strobe: act on its first synced cycle, then wait for release
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         lp_state <= mdbs_pkg::LP_IDLE;
      end
      else
      begin
         unique case (lp_state)
            mdbs_pkg::LP_IDLE: if (lp_rd || lp_wr) lp_state <= mdbs_pkg::LP_HELD;
            mdbs_pkg::LP_HELD: if (!lp_rd && !lp_wr) lp_state <= mdbs_pkg::LP_IDLE;
         endcase
      end
   end

   assign local_wr.en   = (lp_state == mdbs_pkg::LP_IDLE) && lp_wr && !lp_rd &&
                          (pin_sync.sel == mdbs_pkg::LSEL_DATA) && idx_shared;
   assign local_wr.idx  = local_index[4:0];
   assign local_wr.data = pin_sync.data;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         local_index  <= 8'h00;
         local_int_en <= 1'b0;
      end
      else if ((lp_state == mdbs_pkg::LP_IDLE) && lp_wr && !lp_rd)
      begin
         if (pin_sync.sel == mdbs_pkg::LSEL_INDEX)
         begin
            local_index <= pin_sync.data;
         end
         if (pin_sync.sel == mdbs_pkg::LSEL_STATUS)
         begin
            local_int_en <= pin_sync.data[mdbs_pkg::CTRL_EN_BIT];
         end
      end
   end

   // Ready rises only once shared read data stands on the bus
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         local_data_bus_out  <= 8'h00;
         local_data_bus_oe_n <= 1'b1;
         local_ready_out     <= 1'b0;
      end
      else if ((lp_state == mdbs_pkg::LP_IDLE) && lp_rd)
      begin
         local_data_bus_oe_n <= 1'b0;
         unique case (pin_sync.sel)
            mdbs_pkg::LSEL_DATA:
            begin
               local_data_bus_out <= idx_shared ? read_shared(local_index[4:0], 1'b0)
                                                : 8'h00;
               local_ready_out    <= idx_shared;
            end
            mdbs_pkg::LSEL_INDEX:  local_data_bus_out <= local_index;
            mdbs_pkg::LSEL_STATUS: local_data_bus_out <= local_status;
            default:               local_data_bus_out <= 8'h00;
         endcase
      end
      else if (!lp_rd)
      begin
         local_data_bus_oe_n <= 1'b1;
         local_ready_out     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Semaphore ports
   // ----------------------------------------------------------------
   // A same-cycle write from both sides is taken host first, then local
   generate
      for (genvar p = 0; p < mdbs_pkg::NUM_SEM; p++)
      begin : g_sem
         logic h_hit;
         logic l_hit;
         assign h_hit = host_wr.en && (host_wr.idx == mdbs_pkg::IDX_SEM0 + 5'(p));
         assign l_hit = local_wr.en && (local_wr.idx == mdbs_pkg::IDX_SEM0 + 5'(p));
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               sem_flag[p]       <= 1'b0;
               sem_test_host[p]  <= 1'b0;
               sem_test_local[p] <= 1'b0;
            end
            else
            begin
               if (h_hit)
               begin
                  sem_test_host[p] <= sem_flag[p];
               end
               if (l_hit)
               begin
                  sem_test_local[p] <= h_hit ? host_wr.data[mdbs_pkg::SEM_FLAG_BIT]
                                             : sem_flag[p];
                  sem_flag[p]       <= local_wr.data[mdbs_pkg::SEM_FLAG_BIT];
               end
               else if (h_hit)
               begin
                  sem_flag[p] <= host_wr.data[mdbs_pkg::SEM_FLAG_BIT];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Mailboxes
   // ----------------------------------------------------------------
   // No reset: content is undefined until written; semaphores never gate access
   generate
      for (genvar m = 0; m < mdbs_pkg::NUM_MBOX; m++)
      begin : g_mbox
         always_ff @(posedge clk)
         begin
            if (local_wr.en && (local_wr.idx == mdbs_pkg::IDX_MBOX_BASE + 5'(m)))
            begin
               mbox[m] <= local_wr.data;
            end
            else if (host_wr.en && (host_wr.idx == mdbs_pkg::IDX_MBOX_BASE + 5'(m)))
            begin
               mbox[m] <= host_wr.data;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Doorbells and enables
   // ----------------------------------------------------------------
   // A set arriving with a clear of the same bit wins, so no request is lost
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         local_db <= 8'h00;
      end
      else
      begin
         local_db <= (local_db & ~((local_wr.en && local_wr.idx == mdbs_pkg::IDX_LDB)
                                   ? local_wr.data : 8'h00))
                   | ((host_wr.en && host_wr.idx == mdbs_pkg::IDX_LDB)
                                   ? host_wr.data : 8'h00);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sys_db <= 8'h00;
      end
      else
      begin
         sys_db <= (sys_db & ~((host_wr.en && host_wr.idx == mdbs_pkg::IDX_SDB)
                               ? host_wr.data : 8'h00))
                 | ((local_wr.en && local_wr.idx == mdbs_pkg::IDX_SDB)
                               ? local_wr.data : 8'h00);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         local_db_en <= 8'h00;
         sys_db_en   <= 8'h00;
         sys_int_en  <= 1'b0;
      end
      else
      begin
         if (local_wr.en && local_wr.idx == mdbs_pkg::IDX_LDB_EN)
         begin
            local_db_en <= local_wr.data;
         end
         if (host_wr.en && host_wr.idx == mdbs_pkg::IDX_SDB_EN)
         begin
            sys_db_en <= host_wr.data;
         end
         if (host_wr.en && host_wr.idx == mdbs_pkg::IDX_SYS_INT_CTRL)
         begin
            sys_int_en <= host_wr.data[mdbs_pkg::CTRL_EN_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt pins
   // ----------------------------------------------------------------
   // No other internal sources live here; doorbells are the only inputs to the OR
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         board_irq_out <= 1'b0;
         host_irq_out  <= 1'b0;
      end
      else
      begin
         board_irq_out <= local_int_en && local_db_active;
         host_irq_out  <= sys_int_en && sys_db_active;
      end
   end

endmodule

`default_nettype wire

// ==== pkg/mdbs_pkg.sv ====
// Constants, carriers and decode helpers of the mailbox/doorbell/semaphore block
`default_nettype none

package mdbs_pkg;

   // ----------------------------------------------------------------
   // Shared register indices
   // ----------------------------------------------------------------
   localparam logic [4:0] IDX_SYS_INT_CTRL = 5'h09;
   localparam logic [4:0] IDX_SEM0         = 5'h0A;
   localparam logic [4:0] IDX_SEM1         = 5'h0B;
   localparam logic [4:0] IDX_LDB_EN       = 5'h0C;
   localparam logic [4:0] IDX_LDB          = 5'h0D;
   localparam logic [4:0] IDX_SDB          = 5'h0E;
   localparam logic [4:0] IDX_SDB_EN       = 5'h0F;
   localparam logic [4:0] IDX_MBOX_BASE    = 5'h10;
   localparam int         NUM_SEM          = 2;
   localparam int         NUM_MBOX         = 16;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SEM_FLAG_BIT = 0;
   localparam int SEM_TEST_BIT = 1;
   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_DB_BIT  = 1;
   localparam int CTRL_IRQ_BIT = 2;

   // ----------------------------------------------------------------
   // Local port register selects and bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0] LSEL_DATA   = 2'h0;
   localparam logic [1:0] LSEL_INDEX  = 2'h1;
   localparam logic [1:0] LSEL_STATUS = 2'h2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int         ADDR_W      = 12;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       en;
      logic [4:0] idx;
      logic [7:0] data;
   } mdbs_wr_s;

   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic [1:0] sel;
      logic [7:0] data;
   } mdbs_lpin_s;

   typedef enum logic [0:0] {
      LP_IDLE = 1'b0,
      LP_HELD = 1'b1
   } mdbs_lp_e;

   function automatic logic is_shared(input logic [7:0] idx);
      is_shared = (idx[7:5] == 3'h0) &&
                  ((idx[4:0] >= IDX_SYS_INT_CTRL) || (idx[4:0] >= IDX_MBOX_BASE));
   endfunction

endpackage

`default_nettype wire

// ==== verification/mdbs_chk.sv ====
// Port checker of the mailbox/doorbell/semaphore block
`default_nettype none
module mdbs_chk
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        local_chip_select_n,
   input wire logic        local_read_strobe_n,
   input wire logic        local_write_strobe_n,
   input wire logic        local_data_bus_oe_n,
   input wire logic        local_ready_out,
   input wire logic        board_irq_out,
   input wire logic        host_irq_out
);
   // ----------------------------------------------------------------
   // Port relations
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Five samples covers the two-flop synchroniser plus the answer edge
   sequence rd_held;
      (!local_chip_select_n && !local_read_strobe_n)[*5];
   endsequence
   sequence wr_held;
      (!local_chip_select_n && !local_write_strobe_n && local_read_strobe_n)[*5];
   endsequence
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_ready_drives_bus: assert property (local_ready_out |-> !local_data_bus_oe_n)
      else $error("ready without driven bus");
   a_idle_bus_free: assert property (local_chip_select_n[*5] |-> local_data_bus_oe_n && !local_ready_out)
      else $error("bus driven while idle");
   a_read_drives_bus: assert property (rd_held |-> !local_data_bus_oe_n)
      else $error("read not answered");
   a_write_no_drive: assert property (wr_held |-> local_data_bus_oe_n)
      else $error("bus driven during write");
   a_byte_lane_only: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read lanes not zero");
   a_read_data_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while held");
   a_write_answer_time: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_irq_quiet_reset: assert property ($rose(rst_n) |-> !board_irq_out && !host_irq_out)
      else $error("interrupt out of reset");
endmodule

bind mdbs_top mdbs_chk u_chk (.*);
`default_nettype wire

// ==== verification/mdbs_lp_model.sv ====
// Behavioural local processor on the far side of the local port
`default_nettype none
module mdbs_lp_model
(
   input  wire logic       clk,
   output var  logic       cs_n,
   output var  logic       rd_n,
   output var  logic       wr_n,
   output var  logic [1:0] sel,
   output var  logic [7:0] dout,
   input  wire logic [7:0] din,
   input  wire logic       rdy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] last;
   logic       seen_rdy;
   // ----------------------------------------------------------------
   // Strobed access
   // ----------------------------------------------------------------
   initial
   begin
      {cs_n, rd_n, wr_n} = 3'h7;
      sel = 2'h0;
      dout = 8'h00;
   end
   // Strobe held six cycles so slow synchronisation still sees it
   task automatic xfer(input logic [1:0] s, input logic w, input logic [7:0] wd);
      begin
         cs_n <= 1'b0;
         rd_n <= w;
         wr_n <= !w;
         sel <= s;
         dout <= w ? wd : ~dout;
         repeat (6) @(posedge clk);
         last = din;
         seen_rdy = rdy;
         {cs_n, rd_n, wr_n} <= 3'h7;
         dout <= ~dout;
         repeat (5) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// ==== verification/mailbox_doorbell_semaphore_tb.sv ====
// Self-checking bench of the mailbox/doorbell/semaphore block
`default_nettype none
module mailbox_doorbell_semaphore_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                        clk;
   logic                        rst_n;
   logic [mdbs_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]                 s_axi_wdata, s_axi_rdata;
   logic [3:0]                  s_axi_wstrb;
   logic [1:0]                  s_axi_bresp, s_axi_rresp;
   logic [7:0]                  local_data_bus_in, local_data_bus_out;
   logic [4:0]                  ix;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, local_data_bus_oe_n;
   logic local_chip_select_n, local_read_strobe_n, local_write_strobe_n, local_ready_out;
   logic local_reg_select_0, local_reg_select_1, board_irq_out, host_irq_out;
   int   error_cnt = 0;
   int   n_compared = 0;
   int   cyc = 0;
   mdbs_top uut (.*);
   mdbs_lp_model lp (.clk(clk), .cs_n(local_chip_select_n), .rd_n(local_read_strobe_n),
      .wr_n(local_write_strobe_n), .sel({local_reg_select_1, local_reg_select_0}),
      .dout(local_data_bus_in), .din(local_data_bus_out), .rdy(local_ready_out));
   // ----------------------------------------------------------------
   // Bus tasks and checks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      begin
         n_compared++;
         if (g !== e)
         begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task automatic wrap_up;
      begin
         $display("errors %0d compared %0d", error_cnt, n_compared);
         if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // Address and data are released independently, whichever is taken first
   task automatic hw(input logic [4:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
      logic pa;
      logic pw;
      begin
         pa = 1'b1;
         pw = 1'b1;
         s_axi_awaddr <= {5'h00, i, 2'h0};
         s_axi_wdata <= {24'h000000, d};
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
         do
         begin
            @(posedge clk);
            if (s_axi_awready) pa = 1'b0;
            if (s_axi_wready) pw = 1'b0;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
         end
         while (pa || pw);
         do @(posedge clk); while (!s_axi_bvalid);
         chk("bresp", {6'h00, er}, {6'h00, s_axi_bresp});
         s_axi_bready <= 1'b0;
         @(posedge clk);
      end
   endtask
   task automatic hr(input logic [4:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
      begin
         s_axi_araddr <= {5'h00, i, 2'h0};
         {s_axi_arvalid, s_axi_rready} <= 2'h2;
         do @(posedge clk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         // One cycle with rready low, so the read data must be held
         @(posedge clk);
         s_axi_rready <= 1'b1;
         do @(posedge clk); while (!s_axi_rvalid);
         chk("rdata", e, s_axi_rdata[7:0]);
         chk("rresp", {6'h00, er}, {6'h00, s_axi_rresp});
         s_axi_rready <= 1'b0;
         @(posedge clk);
      end
   endtask
   task automatic lw(input logic [4:0] i, input logic [7:0] d);
      begin
         lp.xfer(mdbs_pkg::LSEL_INDEX, 1'b1, {3'h0, i});
         lp.xfer(mdbs_pkg::LSEL_DATA, 1'b1, d);
      end
   endtask
   task automatic lr(input logic [4:0] i, input logic [7:0] e, input logic r = 1'b1);
      begin
         lp.xfer(mdbs_pkg::LSEL_INDEX, 1'b1, {3'h0, i});
         lp.xfer(mdbs_pkg::LSEL_DATA, 1'b0, 8'h00);
         chk("local data", e, lp.last);
         chk("local ready", {7'h00, r}, {7'h00, lp.seen_rdy});
      end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         wrap_up;
      end
   end
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
      s_axi_wstrb = 4'hF;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int s = 0; s < mdbs_pkg::NUM_SEM; s++)
      begin
         ix = mdbs_pkg::IDX_SEM0 + 5'(s);
         hr(ix, 8'h00);
         hw(ix, 8'h01);
         hr(ix, 8'h01);
         lw(ix, 8'hFF);
         lr(ix, 8'h03);
         hr(ix, 8'h01);
         hw(ix, 8'h00);
         hr(ix, 8'h02);
      end
      lw(mdbs_pkg::IDX_SEM0, 8'h01);
      for (int m = 0; m < mdbs_pkg::NUM_MBOX; m++)
      begin
         ix = mdbs_pkg::IDX_MBOX_BASE + 5'(m);
         hw(ix, 8'h5A ^ 8'(m));
         lr(ix, 8'h5A ^ 8'(m));
         lw(ix, 8'hC3 ^ 8'(m));
         hr(ix, 8'hC3 ^ 8'(m));
      end
      hr(5'h01, 8'h00, mdbs_pkg::RESP_SLVERR);
      hw(5'h01, 8'hFF, mdbs_pkg::RESP_SLVERR);
      lr(5'h01, 8'h00, 1'b0);
      hr(mdbs_pkg::IDX_LDB, 8'h00);
      lp.xfer(mdbs_pkg::LSEL_STATUS, 1'b1, 8'h01);
      lw(mdbs_pkg::IDX_LDB_EN, 8'h0F);
      hw(mdbs_pkg::IDX_LDB, 8'h30);
      chk("board irq", 8'h00, {7'h00, board_irq_out});
      hw(mdbs_pkg::IDX_LDB, 8'h01);
      chk("board irq", 8'h01, {7'h00, board_irq_out});
      lp.xfer(mdbs_pkg::LSEL_STATUS, 1'b0, 8'h00);
      chk("local status", 8'h07, lp.last);
      lr(mdbs_pkg::IDX_LDB, 8'h31);
      lw(mdbs_pkg::IDX_LDB, 8'h01);
      lr(mdbs_pkg::IDX_LDB, 8'h30);
      chk("board irq", 8'h00, {7'h00, board_irq_out});
      lw(mdbs_pkg::IDX_LDB_EN, 8'hFF);
      chk("board irq", 8'h01, {7'h00, board_irq_out});
      hw(mdbs_pkg::IDX_SYS_INT_CTRL, 8'h01);
      hw(mdbs_pkg::IDX_SDB_EN, 8'h02);
      lw(mdbs_pkg::IDX_SDB, 8'h04);
      chk("host irq", 8'h00, {7'h00, host_irq_out});
      lw(mdbs_pkg::IDX_SDB, 8'h02);
      chk("host irq", 8'h01, {7'h00, host_irq_out});
      hr(mdbs_pkg::IDX_SDB, 8'h06);
      hr(mdbs_pkg::IDX_SYS_INT_CTRL, 8'h07);
      hw(mdbs_pkg::IDX_SYS_INT_CTRL, 8'h00);
      chk("host irq", 8'h00, {7'h00, host_irq_out});
      hw(mdbs_pkg::IDX_SDB, 8'h02);
      hr(mdbs_pkg::IDX_SDB, 8'h04);
      wrap_up;
   end
endmodule
`default_nettype wire
